//--- hw/afaf_alu.v
/*
 * Add-group datapath with flags: accumulator add, index adds through the
 * load-effective-address forms, and add with or without carry of a memory
 * byte. Holds the two accumulators, both index registers and the
 * condition codes, reachable over an Avalon-MM slave.
 * Assumes a bus sequencer that performs each requested cycle, supplies
 * effective addresses, and pulses bus_done per finished cycle.
 */
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
// How it works
// [RULE1] Prebyte form 18 06 adds B to A, writes A, and keeps B.
// [RULE2] Opcode 1A with postbyte E5 adds zero-extended B into X with full 16-bit carry.
// [RULE3] Opcode 19 with postbyte ED adds zero-extended B into Y with full 16-bit carry.
// [RULE4] The index adds take A, B, D or a 5-bit signed constant as the addend.
// [RULE5] Opcodes 89, 99, A9 (and B9) add operand plus carry into A.
// [RULE6] Opcodes C9, D9, E9 (and F9) add operand plus carry into B.
// [RULE7] Opcodes 8B, 9B, AB (and BB) add operand into A without carry.
// [RULE8] Half carry is the carry out of bit 3 of the 8-bit sum.
// [RULE9] Negative follows result bit 7.
// [RULE10] Zero is set only when the 8-bit result is zero.
// [RULE11] Overflow is set when equal operand signs give a result of other sign.
// [RULE12] Carry is the majority of both operand bit 7 and inverted result bit 7.
// [RULE13] Index adds run one program word fetch then one free cycle.
// [RULE14] Program information is requested only as aligned word fetch cycles.
// [RULE15] An optional cycle is a word fetch when misaligned and odd, otherwise free.
// [RULE16] Memory forms run their cycles in mode order and commit after the last.
// [RULE17] The S, X and I condition bits are kept by every add in the group.
`timescale 1ns/100ps
`include "afaf_consts.vh"

module afaf_alu (
	input wire clk_sys,
	input wire rst_n,
	input wire op_valid,
	output wire op_ready,
	input wire op_pre_vld,
	input wire [7:0] op_pre,
	input wire [7:0] op_code,
	input wire [7:0] op_post,
	input wire [7:0] op_imm,
	input wire op_misalign,
	output reg cyc_req_ff,
	output reg [1:0] cyc_kind_ff,
	input wire bus_done,
	input wire [7:0] rd_data,
	output reg done_ff,
	output reg bad_op_ff,
	input wire [2:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// 8-bit add with flag terms, returns {h, n, z, v, c, r}
	function [12:0] afaf_add8;
		input [7:0] a;
		input [7:0] m;
		input cin;
		reg [7:0] r;
		begin
			r = a + m + {7'h00, cin};
			afaf_add8 = {
				// [RULE8] carry out of bit 3
				(a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]),
				// [RULE9] sign of result
				r[7],
				// [RULE10] zero test
				(r == 8'h00),
				// [RULE11] signed overflow
				(a[7] & m[7] & ~r[7]) | (~a[7] & ~m[7] & r[7]),
				// [RULE12] carry majority
				(a[7] & m[7]) | (m[7] & ~r[7]) | (~r[7] & a[7]),
				r};
		end
	endfunction

	// Optional cycle becomes a word fetch only when it is needed
	function [1:0] afaf_opt_cyc;
		input fetch;
		begin
			// [RULE15] fetch or free
			afaf_opt_cyc = fetch ? `AFAF_CYC_PROG : `AFAF_CYC_FREE;
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_ff;
	reg [7:0] acc_a_ff;
	reg [7:0] acc_b_ff;
	reg [15:0] idx_x_ff;
	reg [15:0] idx_y_ff;
	reg [7:0] ccr_ff;
	reg [5:0] seq_ff;
	reg [1:0] last_ff;
	reg [1:0] pos_ff;
	reg [7:0] opnd_ff;
	reg is_lea_ff;
	reg dst_b_ff;
	reg use_c_ff;
	reg lea_y_ff;
	reg [15:0] addend_ff;
	reg rsp_ff;

	// ----------------------------------------------------------------
	// Decode of the offered instruction
	// ----------------------------------------------------------------
	reg dec_ok;
	reg dec_lea;
	reg [5:0] dec_seq;
	reg [1:0] dec_last;
	reg [15:0] dec_addend;
	wire [1:0] dec_mode = op_code[5:4];
	wire mem_form = (op_code[3:0] == 4'h9 && op_code[7]) ||
		(op_code[3:0] == 4'hB && op_code[7:6] == 2'h2);

	// Bus requests have priority while idle so that writes never race a commit
	assign op_ready = (state_ff == ST_IDLE) && !avs_read && !avs_write;
	wire op_take = op_valid && op_ready;

	// Cycle list and addend chosen from opcode and postbyte
	always @* begin
		dec_ok = 1'b0;
		dec_lea = 1'b0;
		dec_seq = 6'h00;
		dec_last = 2'h0;
		dec_addend = 16'h0000;
		if (op_pre_vld) begin
			if (op_pre == `AFAF_PREBYTE_PAGE2 && op_code == `AFAF_OP_ACC_ADD) begin
				dec_ok = 1'b1;
				// [RULE15] prebyte and remainder optional cycles alternate
				dec_seq = {2'h0, afaf_opt_cyc(!op_misalign), afaf_opt_cyc(op_misalign)};
				dec_last = 2'h1;
			end
		end else if (op_code == `AFAF_OP_LEA_X || op_code == `AFAF_OP_LEA_Y) begin
			dec_ok = 1'b1;
			dec_lea = 1'b1;
			// [RULE13] word fetch then free cycle
			dec_seq = {2'h0, `AFAF_CYC_FREE, `AFAF_CYC_PROG};
			dec_last = 2'h1;
			// [RULE4] addend select
			if (op_post[7:5] == 3'h7 && op_post[2] == 1'b1) begin
				case (op_post[1:0])
					2'h0: dec_addend = {8'h00, acc_a_ff};
					2'h1: dec_addend = {8'h00, acc_b_ff};
					2'h2: dec_addend = {acc_a_ff, acc_b_ff};
					default: dec_ok = 1'b0;
				endcase
			end else if (op_post[7] == 1'b0) begin
				dec_addend = {{11{op_post[4]}}, op_post[4:0]};
			end else begin
				dec_ok = 1'b0;
			end
		end else if (mem_form) begin
			dec_ok = 1'b1;
			// [RULE16] per-mode cycle order
			case (dec_mode)
				`AFAF_MODE_IMM: begin
					// [RULE14] aligned word fetch
					dec_seq = {4'h0, `AFAF_CYC_PROG};
					dec_last = 2'h0;
				end
				`AFAF_MODE_EXT: begin
					dec_seq = {afaf_opt_cyc(op_misalign), `AFAF_CYC_PROG, `AFAF_CYC_READ};
					dec_last = 2'h2;
				end
				default: begin
					dec_seq = {`AFAF_CYC_FREE, `AFAF_CYC_PROG, `AFAF_CYC_READ};
					dec_last = 2'h2;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Commit values
	// ----------------------------------------------------------------
	wire [7:0] src_acc = dst_b_ff ? acc_b_ff : acc_a_ff;
	wire [12:0] add_res = afaf_add8(src_acc, opnd_ff, use_c_ff & ccr_ff[`AFAF_CC_C]);
	wire [15:0] lea_base = lea_y_ff ? idx_y_ff : idx_x_ff;
	// [RULE2] [RULE3] 16-bit add, low byte carry ripples high
	wire [15:0] lea_sum = lea_base + addend_ff;
	// [RULE17] S, X and I pass through unchanged
	wire [7:0] ccr_new = {ccr_ff[`AFAF_CC_S], ccr_ff[`AFAF_CC_X], add_res[12],
		ccr_ff[`AFAF_CC_I], add_res[11:8]};
	wire last_done = (state_ff == ST_RUN) && bus_done && (pos_ff == last_ff);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------

	// One wait cycle per access; the answer only comes while idle
	assign avs_waitrequest = (avs_read || avs_write) && !rsp_ff;
	wire bus_wr = avs_write && rsp_ff;

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------

	// Cycle stepping, operand capture and commit
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			acc_a_ff <= `AFAF_RST_ACC;
			acc_b_ff <= `AFAF_RST_ACC;
			idx_x_ff <= `AFAF_RST_IDX;
			idx_y_ff <= `AFAF_RST_IDX;
			ccr_ff <= `AFAF_RST_CCR;
			seq_ff <= 6'h00;
			last_ff <= 2'h0;
			pos_ff <= 2'h0;
			opnd_ff <= 8'h00;
			is_lea_ff <= 1'b0;
			dst_b_ff <= 1'b0;
			use_c_ff <= 1'b0;
			lea_y_ff <= 1'b0;
			addend_ff <= 16'h0000;
			cyc_req_ff <= 1'b0;
			cyc_kind_ff <= `AFAF_CYC_NONE;
			done_ff <= 1'b0;
			bad_op_ff <= 1'b0;
			rsp_ff <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			done_ff <= 1'b0;
			bad_op_ff <= 1'b0;
			rsp_ff <= (avs_read || avs_write) && !rsp_ff && (state_ff == ST_IDLE);
			if ((avs_read || avs_write) && !rsp_ff) begin
				case (avs_address)
					`AFAF_REG_ACC_A: avs_readdata <= {24'h000000, acc_a_ff};
					`AFAF_REG_ACC_B: avs_readdata <= {24'h000000, acc_b_ff};
					`AFAF_REG_IDX_X: avs_readdata <= {16'h0000, idx_x_ff};
					`AFAF_REG_IDX_Y: avs_readdata <= {16'h0000, idx_y_ff};
					`AFAF_REG_CCR: avs_readdata <= {24'h000000, ccr_ff};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
			// Software loads, only possible while idle
			if (bus_wr) begin
				case (avs_address)
					`AFAF_REG_ACC_A: if (avs_byteenable[0]) acc_a_ff <= avs_writedata[7:0];
					`AFAF_REG_ACC_B: if (avs_byteenable[0]) acc_b_ff <= avs_writedata[7:0];
					`AFAF_REG_IDX_X: begin
						if (avs_byteenable[0]) idx_x_ff[7:0] <= avs_writedata[7:0];
						if (avs_byteenable[1]) idx_x_ff[15:8] <= avs_writedata[15:8];
					end
					`AFAF_REG_IDX_Y: begin
						if (avs_byteenable[0]) idx_y_ff[7:0] <= avs_writedata[7:0];
						if (avs_byteenable[1]) idx_y_ff[15:8] <= avs_writedata[15:8];
					end
					`AFAF_REG_CCR: if (avs_byteenable[0]) ccr_ff <= avs_writedata[7:0];
					default: ;
				endcase
			end
			case (state_ff)
				ST_IDLE: begin
					if (op_take && !dec_ok) begin
						bad_op_ff <= 1'b1;
						done_ff <= 1'b1;
					end else if (op_take) begin
						state_ff <= ST_RUN;
						seq_ff <= dec_seq;
						last_ff <= dec_last;
						pos_ff <= 2'h0;
						cyc_req_ff <= 1'b1;
						cyc_kind_ff <= dec_seq[1:0];
						is_lea_ff <= dec_lea;
						addend_ff <= dec_addend;
						lea_y_ff <= (op_code == `AFAF_OP_LEA_Y);
						// [RULE1] B is the operand and stays put
						opnd_ff <= op_pre_vld ? acc_b_ff : op_imm;
						// [RULE6] B destination for the C9 row
						dst_b_ff <= !op_pre_vld && (op_code[7:6] == 2'h3);
						// [RULE5] [RULE7] carry only for the x9 opcodes
						use_c_ff <= !op_pre_vld && (op_code[3:0] == 4'h9);
					end
				end
				ST_RUN: begin
					if (bus_done) begin
						if (cyc_kind_ff == `AFAF_CYC_READ) begin
							opnd_ff <= rd_data;
						end
						if (last_done) begin
							state_ff <= ST_IDLE;
							cyc_req_ff <= 1'b0;
							cyc_kind_ff <= `AFAF_CYC_NONE;
							done_ff <= 1'b1;
						end else begin
							pos_ff <= pos_ff + 2'h1;
							cyc_kind_ff <= (pos_ff == 2'h0) ? seq_ff[3:2] : seq_ff[5:4];
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
			// [RULE16] result and flags land after the final cycle
			if (last_done && is_lea_ff) begin
				if (lea_y_ff) begin
					idx_y_ff <= lea_sum;
				end else begin
					idx_x_ff <= lea_sum;
				end
			end else if (last_done) begin
				if (dst_b_ff) begin
					acc_b_ff <= add_res[7:0];
				end else begin
					acc_a_ff <= add_res[7:0];
				end
				ccr_ff <= ccr_new;
			end
		end
	end

endmodule

//--- include/afaf_consts.vh
/*
 * Constants for the add-group datapath: opcodes, addressing-mode codes,
 * bus cycle kinds, condition code bit positions, reset values and
 * register word offsets.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef AFAF_CONSTS_VH
`define AFAF_CONSTS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define AFAF_PREBYTE_PAGE2 8'h18
`define AFAF_OP_ACC_ADD 8'h06
`define AFAF_OP_LEA_X 8'h1A
`define AFAF_OP_LEA_Y 8'h19
`define AFAF_OP_ADC_A_IMM 8'h89
`define AFAF_OP_ADC_A_DIR 8'h99
`define AFAF_OP_ADC_A_IDX 8'hA9
`define AFAF_OP_ADC_A_EXT 8'hB9
`define AFAF_OP_ADC_B_IMM 8'hC9
`define AFAF_OP_ADC_B_DIR 8'hD9
`define AFAF_OP_ADC_B_IDX 8'hE9
`define AFAF_OP_ADC_B_EXT 8'hF9
`define AFAF_OP_ADD_A_IMM 8'h8B
`define AFAF_OP_ADD_A_DIR 8'h9B
`define AFAF_OP_ADD_A_IDX 8'hAB
`define AFAF_OP_ADD_A_EXT 8'hBB

// ----------------------------------------------------------------
// Addressing mode field, opcode bits 5:4
// ----------------------------------------------------------------
`define AFAF_MODE_IMM 2'h0
`define AFAF_MODE_DIR 2'h1
`define AFAF_MODE_IDX 2'h2
`define AFAF_MODE_EXT 2'h3

// ----------------------------------------------------------------
// Bus cycle kinds shown to the sequencer
// ----------------------------------------------------------------
`define AFAF_CYC_NONE 2'h0
`define AFAF_CYC_PROG 2'h1
`define AFAF_CYC_READ 2'h2
`define AFAF_CYC_FREE 2'h3

// ----------------------------------------------------------------
// Condition code bit positions
// ----------------------------------------------------------------
`define AFAF_CC_S 7
`define AFAF_CC_X 6
`define AFAF_CC_H 5
`define AFAF_CC_I 4
`define AFAF_CC_N 3
`define AFAF_CC_Z 2
`define AFAF_CC_V 1
`define AFAF_CC_C 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AFAF_RST_ACC 8'h00
`define AFAF_RST_IDX 16'h0000
`define AFAF_RST_CCR 8'hD0

// ----------------------------------------------------------------
// Register word offsets (byte address is four times these)
// ----------------------------------------------------------------
`define AFAF_REG_ACC_A 3'h0
`define AFAF_REG_ACC_B 3'h1
`define AFAF_REG_IDX_X 3'h2
`define AFAF_REG_IDX_Y 3'h3
`define AFAF_REG_CCR 3'h4

`endif

//--- tb/afaf_seq_model.sv
/* Stand-in for the core bus sequencer and memory: answers each cycle request.
   Assumes the block holds its request and kind until the matching bus_done. */
`timescale 1ns/100ps
`include "afaf_consts.vh"
module afaf_seq_model (
	input wire clk_sys,
	input wire rst_n,
	input wire cyc_req_ff,
	input wire [1:0] cyc_kind_ff,
	input wire [1:0] dly,
	input wire [7:0] mem,
	input wire clr,
	output reg bus_done,
	output reg [7:0] rd_data,
	output reg [7:0] kinds
);
reg [1:0] cnt;
// Finish a cycle after dly waits and log its kind; stale data keeps toggling
always @(posedge clk_sys) begin
	bus_done <= 1'b0;
	rd_data <= ~rd_data;
	if (!rst_n || clr) begin
		kinds <= 8'h00;
		cnt <= 2'h0;
		rd_data <= 8'h5A;
	end else if (cyc_req_ff && !bus_done) begin
		if (cnt == dly) begin
			bus_done <= 1'b1;
			cnt <= 2'h0;
			kinds <= {kinds[5:0], cyc_kind_ff};
			if (cyc_kind_ff == `AFAF_CYC_READ) rd_data <= mem;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
end
endmodule

//--- tb/afaf_monitor.sv
/* Checker for cycle order and completion timing of the add-group block.
   Assumes it is bound to afaf_alu and sees only its ports. */
`timescale 1ns/100ps
`include "afaf_consts.vh"
module afaf_monitor (
	input wire clk_sys,
	input wire rst_n,
	input wire op_valid,
	input wire op_ready,
	input wire op_pre_vld,
	input wire [7:0] op_pre,
	input wire [7:0] op_code,
	input wire [7:0] op_post,
	input wire op_misalign,
	input wire cyc_req_ff,
	input wire [1:0] cyc_kind_ff,
	input wire bus_done,
	input wire done_ff,
	input wire bad_op_ff
);
reg lea_ff;
wire take = op_valid && op_ready && !op_pre_vld;
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
// Index add of B (1A E5 or 19 ED) in flight, so its cycle pair can be followed
always @(posedge clk_sys) begin
	if (!rst_n) lea_ff <= 1'b0;
	else if (op_valid && op_ready) lea_ff <= take &&
		((op_code == `AFAF_OP_LEA_X && op_post == 8'hE5) ||
		(op_code == `AFAF_OP_LEA_Y && op_post == 8'hED));
	else if (done_ff) lea_ff <= 1'b0;
end
take_start_a: assert property (op_valid && op_ready |=> cyc_req_ff ^ done_ff)
	else $error("take gave no cycle");
imm_fetch_a: assert property (take && op_code == `AFAF_OP_ADC_A_IMM |=> cyc_kind_ff == 2'h1)
	else $error("immediate not a word fetch");
dir_read_a: assert property (take && op_code == `AFAF_OP_ADC_A_DIR |=> cyc_kind_ff == 2'h2)
	else $error("direct not read first");
opt_cycle_a: assert property (op_valid && op_ready && op_pre_vld && op_pre == 8'h18
	&& op_code == 8'h06 |=> cyc_kind_ff == ($past(op_misalign) ? 2'h1 : 2'h3))
	else $error("optional cycle kind");
lea_free_a: assert property (lea_ff && bus_done && cyc_kind_ff == 2'h1
	|=> cyc_req_ff && cyc_kind_ff == 2'h3) else $error("no free after fetch");
lea_end_a: assert property (lea_ff && bus_done && cyc_kind_ff == 2'h3 |=> done_ff)
	else $error("index add too long");
kind_hold_a: assert property (cyc_req_ff && !bus_done |=> cyc_req_ff && $stable(cyc_kind_ff))
	else $error("cycle changed early");
kind_set_a: assert property (cyc_req_ff |-> cyc_kind_ff != 2'h0)
	else $error("request without kind");
done_pulse_a: assert property (done_ff |=> !done_ff)
	else $error("done held");
done_idle_a: assert property (done_ff |-> !cyc_req_ff)
	else $error("done while busy");
cover property (lea_ff && done_ff);
cover property (done_ff && bad_op_ff);
cover property (bus_done && cyc_kind_ff == 2'h2);
endmodule
bind afaf_alu afaf_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
	.op_ready(op_ready), .op_pre_vld(op_pre_vld), .op_pre(op_pre), .op_code(op_code),
	.op_post(op_post),
	.op_misalign(op_misalign), .cyc_req_ff(cyc_req_ff), .cyc_kind_ff(cyc_kind_ff),
	.bus_done(bus_done), .done_ff(done_ff), .bad_op_ff(bad_op_ff));

//--- tb/tb_top.sv
/* Self-checking bench: instruction table, register bus, refusals and reset.
   Assumes the sequencer stand-in on the cycle port. */
`timescale 1ns/100ps
`include "afaf_consts.vh"
module tb_top;
typedef struct {logic pv; logic [7:0] op, post, mem; logic mis; logic [7:0] kinds;} afaf_row_t;
logic clk_sys = 0, rst_n = 0, op_valid = 0, op_pre_vld = 0, op_misalign = 0, clr = 0;
logic avs_read = 0, avs_write = 0;
logic [7:0] op_code = 8'h00, op_post = 8'h00, op_imm = 8'h00, mem = 8'h00, ra, rb, rc;
logic [7:0] op_pre = 8'h18;
logic [2:0] avs_address = 3'h0;
logic [31:0] avs_writedata = 32'h0, q;
logic [3:0] avs_byteenable = 4'hF;
logic [1:0] dly = 2'h0;
logic [15:0] rx, ry, ad;
wire op_ready, cyc_req_ff, bus_done, done_ff, bad_op_ff, avs_waitrequest;
wire [1:0] cyc_kind_ff;
wire [7:0] rd_data, kinds;
wire [31:0] avs_readdata;
int n_fail = 0, samples_checked = 0;
afaf_row_t rows[20] = '{'{1,8'h06,0,0,0,8'h0D}, '{1,8'h06,0,0,1,8'h07},
	'{0,8'h1A,8'hE5,0,0,8'h07}, '{0,8'h1A,8'hE4,0,0,8'h07}, '{0,8'h1A,8'hE6,0,0,8'h07},
	'{0,8'h1A,8'h0F,0,0,8'h07}, '{0,8'h19,8'hED,0,0,8'h07}, '{0,8'h19,8'h10,0,0,8'h07},
	'{0,8'h89,0,8'h00,0,8'h01}, '{0,8'h99,0,8'h80,0,8'h27}, '{0,8'hA9,0,8'h7F,0,8'h27},
	'{0,8'hB9,0,8'hFF,0,8'h27}, '{0,8'hC9,0,8'h0F,0,8'h01}, '{0,8'hD9,0,8'hF1,0,8'h27},
	'{0,8'hE9,0,8'h00,0,8'h27}, '{0,8'hF9,0,8'h70,1,8'h25}, '{0,8'h8B,0,8'h80,0,8'h01},
	'{0,8'h9B,0,8'h08,0,8'h27}, '{0,8'hAB,0,8'hFF,0,8'h27}, '{0,8'hBB,0,8'h01,1,8'h25}};
afaf_row_t bads[4] = '{'{1,8'h07,0,0,0,0}, '{0,8'hCB,0,0,0,0}, '{0,8'h1A,8'hFF,0,0,0},
	'{0,8'h49,0,0,0,0}};
afaf_alu dut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
	.op_pre_vld(op_pre_vld), .op_pre(op_pre), .op_code(op_code), .op_post(op_post),
	.op_imm(op_imm), .op_misalign(op_misalign), .cyc_req_ff(cyc_req_ff),
	.cyc_kind_ff(cyc_kind_ff), .bus_done(bus_done), .rd_data(rd_data), .done_ff(done_ff),
	.bad_op_ff(bad_op_ff), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
afaf_seq_model seq (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_req_ff(cyc_req_ff),
	.cyc_kind_ff(cyc_kind_ff), .dly(dly), .mem(mem), .clr(clr), .bus_done(bus_done),
	.rd_data(rd_data), .kinds(kinds));
initial forever #10 clk_sys = ~clk_sys;
task automatic chk(input string s, input logic [31:0] e, g);
	samples_checked++;
	if (g !== e) begin
		n_fail++;
		$display("unexpected %s expected %h seen %h", s, e, g);
	end
endtask
// One Avalon access; the request stands until waitrequest is seen low
task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
	@(posedge clk_sys);
	avs_address <= a;
	avs_writedata <= d;
	avs_write <= w;
	avs_read <= !w;
	// Sampled in the edge's own step, so the values seen are those before it
	do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
	q = avs_readdata;
	avs_read <= 1'b0;
	avs_write <= 1'b0;
endtask
task automatic check_regs;
	logic [31:0] ev[5];
	ev = '{{24'h0, ra}, {24'h0, rb}, {16'h0, rx}, {16'h0, ry}, {24'h0, rc}};
	for (int k = 0; k < 5; k++) begin
		bus(1'b0, k[2:0], 32'h0);
		chk($sformatf("register %0d", k), ev[k], q);
	end
endtask
task automatic setregs(input logic [7:0] a, b, c, input logic [15:0] x, y);
	ra = a; rb = b; rc = c; rx = x; ry = y;
	for (int k = 0; k < 5; k++) bus(1'b1, k[2:0], k == 2 ? x : k == 3 ? y : k == 4 ? c : k ? b : a);
endtask
// Reference 8-bit add with all five arithmetic flags
task automatic add8(input logic [7:0] p, m, input logic c, output logic [7:0] r);
	r = p + m + c;
	rc[5] = ({1'b0, p[3:0]} + m[3:0] + c) > 5'hF;
	rc[3] = r[7];
	rc[2] = (r == 8'h00);
	rc[1] = (p[7] & m[7] & ~r[7]) | (~p[7] & ~m[7] & r[7]);
	rc[0] = (p[7] & m[7]) | (m[7] & ~r[7]) | (~r[7] & p[7]);
endtask
task automatic issue(input afaf_row_t w, input logic bad);
	@(posedge clk_sys);
	op_valid <= 1'b1; op_pre_vld <= w.pv; op_code <= w.op; op_post <= w.post;
	op_misalign <= w.mis; mem <= w.mem; clr <= 1'b1;
	op_imm <= (w.op[5:4] == 2'h0) ? w.mem : ~w.mem;
	do @(negedge clk_sys); while (op_ready !== 1'b1);
	@(posedge clk_sys);
	op_valid <= 1'b0; clr <= 1'b0;
	do @(negedge clk_sys); while (done_ff !== 1'b1);
	chk("refusal flag", {31'h0, bad}, {31'h0, bad_op_ff});
	chk("cycle kinds", bad ? 32'h0 : {24'h0, w.kinds}, {24'h0, kinds});
endtask
task automatic step(input afaf_row_t w);
	if (w.op == 8'h06) add8(ra, rb, 1'b0, ra);
	else if (w.op[7:4] == 4'h1) begin
		ad = w.post[7] ? (w.post[1] ? {ra, rb} : {8'h00, w.post[0] ? rb : ra})
			: {{11{w.post[4]}}, w.post[4:0]};
		if (w.op[0]) ry = ry + ad; else rx = rx + ad;
	end else if (w.op[6]) add8(rb, w.mem, rc[0], rb);
	else add8(ra, w.mem, w.op[1] ? 1'b0 : rc[0], ra);
	issue(w, 1'b0);
	check_regs;
endtask
task report_and_stop;
	$display("checks %0d mismatches %0d", samples_checked, n_fail);
	if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
	else $display("Testbench failed");
	$finish;
endtask
// Watchdog at 20000 cycles, far beyond the expected several hundred cycles
initial begin
	#400000;
	n_fail++;
	report_and_stop;
end
initial begin
	ra = 8'h00; rb = 8'h00; rx = 16'h0; ry = 16'h0; rc = 8'hD0;
	repeat (20) @(posedge clk_sys);
	rst_n <= 1'b1;
	check_regs;
	setregs(8'h3C, 8'hC8, 8'hD1, 16'h12F0, 16'hFFF0);
	foreach (rows[i]) step(rows[i]);
	// Zero result with carry and overflow, then carry into a slow direct add
	setregs(8'h80, 8'h00, 8'hD0, 16'hFFFF, 16'h0001);
	step(rows[16]);
	dly <= 2'h2;
	fork
		step(rows[13]);
		begin
			bus(1'b0, 3'h3, 32'h0);
			chk("y beside op", {16'h0, ry}, q);
		end
	join
	// Refused codes change nothing
	foreach (bads[i]) begin
		issue(bads[i], 1'b1);
		check_regs;
	end
	// A prebyte other than the page-two one is refused as well
	op_pre <= 8'h11;
	issue(rows[0], 1'b1);
	op_pre <= 8'h18;
	check_regs;
	// Unmapped place and byte lanes
	bus(1'b1, 3'h6, 32'hFFFFFFFF);
	bus(1'b0, 3'h6, 32'h0);
	chk("unmapped", 32'h0, q);
	avs_byteenable <= 4'h1;
	bus(1'b1, 3'h2, 32'h0000ABCD);
	avs_byteenable <= 4'hF;
	rx[7:0] = 8'hCD;
	check_regs;
	// Reset again between operations, with the block idle
	@(posedge clk_sys);
	rst_n <= 1'b0;
	repeat (2) @(posedge clk_sys);
	rst_n <= 1'b1;
	ra = 8'h00; rb = 8'h00; rx = 16'h0; ry = 16'h0; rc = 8'hD0;
	check_regs;
	report_and_stop;
end
endmodule
